/* File: tlp_timeout_report_count.sv */
// Per-port time-out discard, status, reporting control and discard count registers.
//
// Overview of operation
// - A packet at a queue head older than 50 ms is discarded.
// - Each queue has its own write-one-to-clear time-out status flag, bits 0 to 3.
// - Reporting acts only when a status flag goes from zero to one.
// - Setting 0 suppresses, 1 correctable, 2 non-fatal, 3 fatal error message.
// - Posted setting at bits 1:0, resets to 2, sticky, writable.
// - Non-posted setting at bits 3:2, resets to 0, sticky, writable.
// - Completion setting at bits 5:4, resets to 0, sticky, writable.
// - Inserted setting at bits 7:6, resets to 2, sticky; bits 31:8 read zero.
// - Posted discard count in bits 7:0 increments per posted discard.
// - Non-posted discard count in bits 15:8 increments per non-posted discard.
// - Completion discard count in bits 23:16 increments per completion discard.
// - Inserted discard count in bits 31:24 increments per inserted discard.
// - Each count stops at all ones and never wraps.
// - Reading the counts returns them and clears them; reset value zero, sticky.
`timescale 1ns/1ns
module tlp_timeout_report_count #(
  parameter int unsigned AGE_LIMIT = timeout_pkg::AGE_LIMIT_CYCLES
) (
  // Core clock and power-on or fundamental reset.
  input wire logic clk,
  input wire logic rstn,
  // Hot or link reset, one cycle or longer, on the core clock.
  input wire logic link_reset,
  // Queue heads of the port input buffer.
  input wire logic [3:0] head_valid,
  input wire logic [3:0] head_pop,
  // Age discard command to the port input buffer.
  output logic [3:0] discard_q,
  // Error message requests toward the root.
  output timeout_pkg::err_msg_t err_msg_q,
  // Software register port.
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q
);

  localparam int NQ = timeout_pkg::NUM_QUEUES;
  localparam int AGE_W = $clog2(AGE_LIMIT);
  localparam logic [AGE_W-1:0] AGE_LAST = AGE_W'(AGE_LIMIT - 1);
  localparam int CW = timeout_pkg::COUNT_W;

  // Returns the reporting setting of one queue from the control register.
  function automatic timeout_pkg::report_t report_of(input logic [7:0] ctrl, input int q);
    logic [1:0] field;
    field = ctrl[q*timeout_pkg::REPORT_FIELD_W +: timeout_pkg::REPORT_FIELD_W];
    return timeout_pkg::report_t'(field);
  endfunction : report_of

  // Register request carried as one bundle.
  timeout_pkg::reg_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Address decode.
  wire sel_status = (req.addr == timeout_pkg::STATUS_OFFSET);
  wire sel_control = (req.addr == timeout_pkg::CONTROL_OFFSET);
  wire sel_counts = (req.addr == timeout_pkg::COUNTS_OFFSET);
  wire wr_status = req.wr && sel_status;
  wire wr_control = req.wr && sel_control;
  wire rd_counts = req.rd && sel_counts;

  // Per-queue age tracking.
  logic [AGE_W-1:0] age_q [NQ];
  logic [AGE_W-1:0] age_d [NQ];
  logic [3:0] hit;

  // The age counter restarts when the head leaves, so the next packet is timed from
  // the moment it reaches the head; its time in the queue before that is not counted.
  generate
    for (genvar i = 0; i < NQ; i++)
    begin : g_age
      assign hit[i] = head_valid[i] && !head_pop[i] && (age_q[i] == AGE_LAST);
      assign age_d[i] = (link_reset || !head_valid[i] || head_pop[i] || hit[i]) ? '0
                      : AGE_W'(age_q[i] + 1'b1);

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          age_q[i] <= '0;
        else
          age_q[i] <= age_d[i];
      end

      a_discard_age: assert property (@(posedge clk) disable iff (!rstn)
        discard_q[i] |-> ($past(age_q[i]) == AGE_LAST && $past(head_valid[i]))
      ) else $error("discard issued before the age limit");
    end
  endgenerate

  // Discard command pulses one cycle after the age limit is reached.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      discard_q <= 4'h0;
    else
      discard_q <= hit;
  end

  // Time-out status flags: a new time-out wins over a software clear in the same cycle.
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  wire [3:0] w1c = wr_status ? req.wdata[3:0] : 4'h0;
  assign flags_d = link_reset ? hit : ((flags_q & ~w1c) | hit);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_q <= timeout_pkg::STATUS_RESET;
    else
      flags_q <= flags_d;
  end

  // Reporting control: sticky, so the link reset leaves it alone.
  logic [7:0] control_q;
  wire [7:0] control_d = wr_control ? req.wdata[timeout_pkg::CONTROL_W-1:0] : control_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      control_q <= timeout_pkg::CONTROL_RESET;
    else
      control_q <= control_d;
  end

  // Error reporting on the zero-to-one edge of each flag.
  wire [3:0] rise = hit & ~flags_q;
  logic [3:0] want_cor;
  logic [3:0] want_nonfatal;
  logic [3:0] want_fatal;

  generate
    for (genvar i = 0; i < NQ; i++)
    begin : g_report
      assign want_cor[i] = rise[i] && (report_of(control_q, i) == timeout_pkg::RPT_COR);
      assign want_nonfatal[i] = rise[i] && (report_of(control_q, i) == timeout_pkg::RPT_NONFATAL);
      assign want_fatal[i] = rise[i] && (report_of(control_q, i) == timeout_pkg::RPT_FATAL);
    end
  endgenerate

  timeout_pkg::err_msg_t err_msg_d;
  assign err_msg_d = '{cor: |want_cor, nonfatal: |want_nonfatal, fatal: |want_fatal};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      err_msg_q <= '0;
    else
      err_msg_q <= err_msg_d;
  end

  // Discard counters: one saturating counter per queue, cleared together by a read.
  logic [CW-1:0] count [NQ];

  generate
    for (genvar i = 0; i < NQ; i++)
    begin : g_count
      sat_count #(
        .WIDTH(CW)
      ) u_count (
        .clk(clk),
        .rstn(rstn),
        .inc(hit[i]),
        .clr(rd_counts),
        .count_q(count[i])
      );
    end
  endgenerate

  // Count word layout: posted low, inserted high.
  wire [31:0] count_word = {count[3], count[2], count[1], count[0]};
  wire [31:0] status_word = {28'h000_0000, flags_q};
  wire [31:0] control_word = {24'h00_0000, control_q};

  // Read data selection; unmapped addresses read zero.
  wire [31:0] read_word = sel_status ? status_word
                        : sel_control ? control_word
                        : sel_counts ? count_word
                        : timeout_pkg::UNMAPPED_READ;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h0000_0000;
    else if (req.rd)
      rdata_q <= read_word;
    else
      rdata_q <= 32'h0000_0000;
  end

  a_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
    (hit[0] && wr_status && wdata[0]) |=> flags_q[0])
    else $error("time-out flag lost against a clear");

  a_flag_clears: assert property (@(posedge clk) disable iff (!rstn)
    (flags_q[1] && wr_status && wdata[1] && !hit[1] && !link_reset) |=> !flags_q[1])
    else $error("time-out flag not cleared by write one");

  a_posted_nonfatal: assert property (@(posedge clk) disable iff (!rstn)
    (rise[0] && control_q[1:0] == 2'h2) |=> err_msg_q.nonfatal)
    else $error("posted time-out not reported as non-fatal");

  a_inserted_fatal: assert property (@(posedge clk) disable iff (!rstn)
    (rise[3] && control_q[7:6] == 2'h3) |=> err_msg_q.fatal)
    else $error("inserted time-out not reported as fatal");

  a_nonposted_cor: assert property (@(posedge clk) disable iff (!rstn)
    (rise[1] && control_q[3:2] == 2'h1) |=> err_msg_q.cor)
    else $error("non-posted time-out not reported as correctable");

  a_setting_none: assert property (@(posedge clk) disable iff (!rstn)
    (control_q == 8'h00) |=> (err_msg_q == '0))
    else $error("report sent while all settings suppress it");

  a_edge_only: assert property (@(posedge clk) disable iff (!rstn)
    (flags_q == 4'hf) |=> (err_msg_q == '0))
    else $error("report sent while the flag stayed set");

  a_completion_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_control |=> (control_q[5:4] == $past(wdata[5:4])))
    else $error("completion setting not written");

  a_control_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (link_reset && !wr_control) |=> $stable(control_q))
    else $error("reporting control changed by link reset");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && sel_control) |=> (rdata_q[31:8] == 24'h00_0000))
    else $error("reserved control bits read nonzero");

  a_count_read: assert property (@(posedge clk) disable iff (!rstn)
    rd_counts |=> (rdata_q == $past(count_word)))
    else $error("count read did not return the old value");

  a_counts_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (link_reset && !rd_counts && hit == 4'h0) |=> $stable(count_word))
    else $error("discard counts changed by link reset");

endmodule : tlp_timeout_report_count

/* File: timeout_pkg.sv */
// Constants, register map and carrier types of the time-out reporting and discard count block.
package timeout_pkg;

  // Number of input buffer queues: posted, non-posted, completion, inserted.
  localparam int NUM_QUEUES = 4;

  // Register byte offsets.
  localparam logic [11:0] STATUS_OFFSET = 12'h754;
  localparam logic [11:0] CONTROL_OFFSET = 12'h758;
  localparam logic [11:0] COUNTS_OFFSET = 12'h75c;

  // Field positions of the reporting control register.
  localparam int POSTED_REPORT_LSB = 0;
  localparam int NONPOSTED_REPORT_LSB = 2;
  localparam int COMPLETION_REPORT_LSB = 4;
  localparam int INSERTED_REPORT_LSB = 6;
  localparam int REPORT_FIELD_W = 2;
  localparam int CONTROL_W = 8;

  // Field positions of the discard count register.
  localparam int POSTED_COUNT_LSB = 0;
  localparam int NONPOSTED_COUNT_LSB = 8;
  localparam int COMPLETION_COUNT_LSB = 16;
  localparam int INSERTED_COUNT_LSB = 24;
  localparam int COUNT_W = 8;

  // Reset values.
  localparam logic [1:0] POSTED_REPORT_RESET = 2'h2;
  localparam logic [1:0] NONPOSTED_REPORT_RESET = 2'h0;
  localparam logic [1:0] COMPLETION_REPORT_RESET = 2'h0;
  localparam logic [1:0] INSERTED_REPORT_RESET = 2'h2;
  localparam logic [7:0] CONTROL_RESET = {INSERTED_REPORT_RESET, COMPLETION_REPORT_RESET,
                                          NONPOSTED_REPORT_RESET, POSTED_REPORT_RESET};
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Timing: a packet older than this is discarded.
  localparam int TIMEOUT_MS = 50;
  localparam int CLK_KHZ = 100_000;
  localparam int AGE_LIMIT_CYCLES = TIMEOUT_MS * CLK_KHZ;

  // Reporting modes, in the order of their field codes.
  typedef enum logic [1:0] {
    RPT_NONE,
    RPT_COR,
    RPT_NONFATAL,
    RPT_FATAL
  } report_t;

  // Error message requests toward the root, one pulse per severity.
  typedef struct packed {
    logic cor;
    logic nonfatal;
    logic fatal;
  } err_msg_t;

  // Software register port request.
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : timeout_pkg

/* File: sat_count.sv */
// Saturating event counter that clears on a software read.
`timescale 1ns/1ns
module sat_count #(
  parameter int WIDTH = timeout_pkg::COUNT_W
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic rstn,
  // Event and clearing read.
  input wire logic inc,
  input wire logic clr,
  // Current count.
  output logic [WIDTH-1:0] count_q
);

  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};

  logic [WIDTH-1:0] count_d;
  wire at_max = (count_q == ALL_ONES);
  wire [WIDTH-1:0] count_inc = WIDTH'(count_q + 1'b1);

  // A read returns the old value; an event in the same cycle starts the next count at one.
  assign count_d = clr ? (inc ? WIDTH'(1) : '0)
                 : (inc && !at_max) ? count_inc
                 : count_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= WIDTH'(timeout_pkg::COUNT_RESET);
    else
      count_q <= count_d;
  end

  a_count_saturates: assert property (@(posedge clk) disable iff (!rstn)
    (at_max && !clr) |=> (count_q == ALL_ONES))
    else $error("discard count left its saturated value");

  a_count_steps: assert property (@(posedge clk) disable iff (!rstn)
    (inc && !clr && !at_max) |=> (count_q == WIDTH'($past(count_q) + 1'b1)))
    else $error("discard count did not step by one");

  a_read_clears: assert property (@(posedge clk) disable iff (!rstn)
    (clr && !inc) |=> (count_q == '0))
    else $error("discard count not cleared by read");

  a_read_keeps_event: assert property (@(posedge clk) disable iff (!rstn)
    (clr && inc) |=> (count_q == WIDTH'(1)))
    else $error("discard lost during clearing read");

endmodule : sat_count

/* File: root_msg_model.sv */
// Behavioural model of the root that counts the error messages sent by the port.
`timescale 1ns/1ns
module root_msg_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Error message requests from the port.
  input wire timeout_pkg::err_msg_t err_msg,
  // Messages received per severity.
  output int n_cor,
  output int n_nonfatal,
  output int n_fatal
);
  // Each one-cycle pulse is one message of that severity.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      n_cor <= 0;
      n_nonfatal <= 0;
      n_fatal <= 0;
    end
    else
    begin
      n_cor <= n_cor + int'(err_msg.cor);
      n_nonfatal <= n_nonfatal + int'(err_msg.nonfatal);
      n_fatal <= n_fatal + int'(err_msg.fatal);
    end
  end
endmodule : root_msg_model

/* File: tb_top.sv */
// Self-checking testbench of the time-out reporting and discard count block.
`timescale 1ns/1ns
module tb_top;
  localparam int AGE = 4;
  logic clk;
  logic rstn;
  logic link_reset;
  logic [3:0] head_valid;
  logic [3:0] head_pop;
  logic [3:0] discard_q;
  timeout_pkg::err_msg_t err_msg_q;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata_q;
  logic [31:0] got;
  logic [1:0] mv;
  int n_cor;
  int n_nonfatal;
  int n_fatal;
  int n_mismatch;
  int num_checks;

  tlp_timeout_report_count #(.AGE_LIMIT(AGE)) u_dut (.clk(clk), .rstn(rstn), .link_reset(link_reset),
    .head_valid(head_valid), .head_pop(head_pop), .discard_q(discard_q), .err_msg_q(err_msg_q),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q));
  root_msg_model u_root (.clk(clk), .rstn(rstn), .err_msg(err_msg_q), .n_cor(n_cor),
    .n_nonfatal(n_nonfatal), .n_fatal(n_fatal));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask : reg_rd

  // Holds queue heads until they are discarded, then checks pulse and message.
  task automatic age_out(input logic [3:0] q, input logic [2:0] exp_msg, input bit keep);
    int n;
    @(posedge clk);
    head_valid <= q;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (discard_q !== q && n < 3 * AGE);
    check("discard", {28'h0, discard_q}, {28'h0, q});
    check("err_msg", {29'h0, err_msg_q}, {29'h0, exp_msg});
    if (!keep)
    begin
      @(posedge clk);
      head_valid <= 4'h0;
    end
  endtask : age_out

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    rstn = 1'b0;
    link_reset = 1'b0;
    head_valid = 4'h0;
    head_pop = 4'h0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(timeout_pkg::CONTROL_OFFSET, got);
    check("control", got, 32'h0000_0082);
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0000);
    reg_rd(timeout_pkg::STATUS_OFFSET, got);
    check("status", got, 32'h0000_0000);
    reg_rd(12'h760, got);
    check("unmapped", got, 32'h0000_0000);
    reg_wr(timeout_pkg::COUNTS_OFFSET, 32'hffff_ffff);
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0000);
    reg_wr(timeout_pkg::CONTROL_OFFSET, 32'hffff_ff1b);
    reg_rd(timeout_pkg::CONTROL_OFFSET, got);
    check("control", got, 32'h0000_001b);
    // A normal departure restarts the age, so no discard happens.
    @(posedge clk);
    head_valid <= 4'h4;
    repeat (AGE - 1) @(posedge clk);
    head_pop <= 4'h4;
    @(posedge clk);
    head_pop <= 4'h0;
    repeat (AGE - 1) @(posedge clk);
    head_valid <= 4'h0;
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0000);
    for (int m = 0; m < 4; m++)
    begin
      mv = m[1:0];
      reg_wr(timeout_pkg::CONTROL_OFFSET, {24'h0, {4{mv}}});
      reg_wr(timeout_pkg::STATUS_OFFSET, 32'h0000_000f);
      age_out(4'hf, (m == 0) ? 3'h0 : (3'h4 >> (m - 1)), 1'b0);
      reg_rd(timeout_pkg::STATUS_OFFSET, got);
      check("status", got, 32'h0000_000f);
      age_out(4'hf, 3'h0, 1'b0);
    end
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0808_0808);
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0000);
    check("root msgs", n_cor + 16 * n_nonfatal + 256 * n_fatal, 32'h0000_0111);
    // A clearing read lands on the edge of the next discard.
    age_out(4'h2, 3'h0, 1'b1);
    repeat (AGE - 2) @(posedge clk);
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0100);
    @(posedge clk);
    head_valid <= 4'h0;
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_0100);
    // A status clear that lands on the edge of a new discard leaves the flag set.
    age_out(4'h1, 3'h0, 1'b1);
    repeat (AGE - 2) @(posedge clk);
    reg_wr(timeout_pkg::STATUS_OFFSET, 32'h0000_0001);
    reg_rd(timeout_pkg::STATUS_OFFSET, got);
    check("status", got, 32'h0000_000f);
    @(posedge clk);
    head_valid <= 4'h0;
    // Long hold drives the posted count up to all ones, where it stops.
    @(posedge clk);
    head_valid <= 4'h1;
    repeat (260 * AGE) @(posedge clk);
    head_valid <= 4'h0;
    @(posedge clk);
    link_reset <= 1'b1;
    @(posedge clk);
    link_reset <= 1'b0;
    reg_rd(timeout_pkg::STATUS_OFFSET, got);
    check("status", got, 32'h0000_0000);
    reg_rd(timeout_pkg::CONTROL_OFFSET, got);
    check("control", got, 32'h0000_00ff);
    reg_rd(timeout_pkg::COUNTS_OFFSET, got);
    check("counts", got, 32'h0000_00ff);
    check("fatal msgs", n_fatal, 32'h0000_0001);
    // Only the power-on reset returns the sticky settings to their reset values.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(timeout_pkg::CONTROL_OFFSET, got);
    check("control", got, 32'h0000_0082);
    close_out();
  end
endmodule : tb_top
